// ==== hw/bsctap_regs.svh ====
// constants of the boundary-scan test port: widths, cell positions,
// instruction codes and capture patterns.
// assumes inclusion by bare name from the design files.
`ifndef BSCTAP_REGS_SVH
`define BSCTAP_REGS_SVH

// ==========================================================
// register widths
`define BSCTAP_IR_W 3
`define BSCTAP_ID_W 32
`define BSCTAP_BSR_LEN 109

// ==========================================================
// special boundary cells
`define BSCTAP_OBE_CELL 108
`define BSCTAP_OBE_RESET 1'h0

// ==========================================================
// instruction codes
`define BSCTAP_INS_EXTEST 3'h0
`define BSCTAP_INS_IDCODE 3'h1
`define BSCTAP_INS_SAMPLEZ 3'h2
`define BSCTAP_INS_SAMPLE 3'h4
`define BSCTAP_INS_BYPASS 3'h7

// ==========================================================
// capture values
`define BSCTAP_IR_CAPTURE 3'h1
`define BSCTAP_BYP_CAPTURE 1'h0

// ==========================================================
// identification word, arbitrary value (lsb must stay one)
`define BSCTAP_ID_DEFAULT 32'h0A5C_3E01

// ==========================================================
// input synchroniser depth
`define BSCTAP_SYNC_DEPTH 3

`endif

// ==== hw/bsctap_pkg.sv ====
// types of the boundary-scan test port: controller states and
// data-register selection.
// assumes nothing beyond a SystemVerilog compiler.
package bsctap_pkg;

  // ==========================================================
  // controller states
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SHF_DR = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'hA,
    ST_SHF_IR = 4'hB,
    ST_EX1_IR = 4'hC,
    ST_PAU_IR = 4'hD,
    ST_EX2_IR = 4'hE,
    ST_UPD_IR = 4'hF
  } bsctap_state_type;

  // ==========================================================
  // data register placed between serial in and serial out
  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_IDENT = 2'h1,
    SEL_BOUNDARY = 2'h2
  } bsctap_dr_sel_type;

endpackage

// ==== hw/bsctap_sync.sv ====
// three-stage input synchroniser with agreement filter.
// assumes an asynchronous input; output is a clean level on mclk.
`timescale 1ns/10ps
`include "bsctap_regs.svh"

module bsctap_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic level_q
);

  // ==========================================================
  // synchroniser chain
  logic [`BSCTAP_SYNC_DEPTH-1:0] chain_q;

  // reset to one: matches the pad pull-up of an idle pin
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      chain_q <= {`BSCTAP_SYNC_DEPTH{1'h1}};
    end else begin
      chain_q <= {chain_q[`BSCTAP_SYNC_DEPTH-2:0], pin_in};
    end
  end

  // ==========================================================
  // a change counts only once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'h1;
    end else if (chain_q[1] == chain_q[2]) begin
      level_q <= chain_q[2];
    end
  end

endmodule

// ==== hw/bsctap_top.sv ====
// boundary-scan test access port: controller, instruction, bypass,
// identification and boundary registers, serial output driver.
// assumes the test clock is a slow pin sampled by mclk; pin ring
// states arrive already on mclk; pads carry pull-ups on tms and tdi.
//
// Notes on behaviour
// - test port behaves as a standard boundary-scan access port.
// - inputs taken on test clock rise, outputs changed on its fall.
// - mode select sampled on rise; floating tms or tdi reads high.
// - serial input enters the top bit of the selected register.
// - serial output shows the low bit; registers shift downward.
// - serial output driven only in shift states, else high impedance.
// - five high mode-select samples reset test logic, memory untouched.
// - power-up resets test logic; serial output starts undriven.
// - each instruction places exactly one register in the path.
// - three-bit instruction register, loaded with ident at reset.
// - instruction capture loads pattern 01 into the two low bits.
// - one-bit bypass register cleared on capture, one stage delay.
// - boundary register captures pin ring, then shifts serially.
// - extest, sample and sample-float all capture the pin ring.
// - boundary register holds one cell per bump, spares included.
// - ident instruction captures and shifts a fixed 32-bit word.
// - one boundary cell enables read outputs under extest; resets low.
// - sample-float keeps read outputs undriven while it stays the current instruction.
`timescale 1ns/10ps
`include "bsctap_regs.svh"

module bsctap_top
  import bsctap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic [`BSCTAP_BSR_LEN-1:0] ring_in,
  output logic [`BSCTAP_BSR_LEN-1:0] bsr_par_q,
  output logic extest_q,
  output logic qbus_drive_en_q,
  output logic tap_reset_q
);

  // ==========================================================
  // pin sampling
  logic tck_n;
  logic tck_ns;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_prev_q;
  logic tck_rise;
  logic tck_fall;

  // the test clock is treated as data; tms and tdi share the same
  // latency so they line up with the detected edge; the clock goes in
  // inverted so the pull-up reset level equals its idle low level and
  // no false edge follows reset
  assign tck_n = ~tck_in;

  bsctap_sync u_sync_tck (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(tck_n),
    .level_q(tck_ns)
  );

  assign tck_s = ~tck_ns;

  bsctap_sync u_sync_tms (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(tms_in),
    .level_q(tms_s)
  );

  bsctap_sync u_sync_tdi (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(tdi_in),
    .level_q(tdi_s)
  );

  // reset low: a test clock held low never produces an edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tck_prev_q <= 1'h0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ==========================================================
  // controller, standard access-port sequencing
  bsctap_state_type state_q;
  bsctap_state_type state_d;

  always_comb begin
    unique case (state_q)
      ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: state_d = tms_s ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = tms_s ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: state_d = tms_s ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = tms_s ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // any state reaches reset after five high samples
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // instruction register
  logic [`BSCTAP_IR_W-1:0] ir_shift_q;
  logic [`BSCTAP_IR_W-1:0] ir_q;
  bsctap_dr_sel_type dr_sel;
  logic bsr_instr;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ir_shift_q <= `BSCTAP_IR_CAPTURE;
    end else if (tck_rise) begin
      if (state_q == ST_CAP_IR) begin
        ir_shift_q <= `BSCTAP_IR_CAPTURE;
      end else if (state_q == ST_SHF_IR) begin
        ir_shift_q <= {tdi_s, ir_shift_q[`BSCTAP_IR_W-1:1]};
      end
    end
  end

  // the active instruction changes only on the fall, so the path
  // never swaps in the middle of a rise-edge shift
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ir_q <= `BSCTAP_INS_IDCODE;
    end else if (tck_fall) begin
      if (state_q == ST_RESET) begin
        ir_q <= `BSCTAP_INS_IDCODE;
      end else if (state_q == ST_UPD_IR) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // reserved codes fall back to bypass so the path stays one bit
  always_comb begin
    unique case (ir_q)
      `BSCTAP_INS_IDCODE: dr_sel = SEL_IDENT;
      `BSCTAP_INS_EXTEST,
      `BSCTAP_INS_SAMPLEZ,
      `BSCTAP_INS_SAMPLE: dr_sel = SEL_BOUNDARY;
      default: dr_sel = SEL_BYPASS;
    endcase
  end

  assign bsr_instr = (dr_sel == SEL_BOUNDARY);

  // ==========================================================
  // bypass register
  logic byp_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      byp_q <= `BSCTAP_BYP_CAPTURE;
    end else if (tck_rise && dr_sel == SEL_BYPASS) begin
      if (state_q == ST_CAP_DR) begin
        byp_q <= `BSCTAP_BYP_CAPTURE;
      end else if (state_q == ST_SHF_DR) begin
        byp_q <= tdi_s;
      end
    end
  end

  // ==========================================================
  // identification register
  logic [`BSCTAP_ID_W-1:0] id_shift_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      id_shift_q <= `BSCTAP_ID_DEFAULT;
    end else if (tck_rise && dr_sel == SEL_IDENT) begin
      if (state_q == ST_CAP_DR) begin
        id_shift_q <= `BSCTAP_ID_DEFAULT;
      end else if (state_q == ST_SHF_DR) begin
        id_shift_q <= {tdi_s, id_shift_q[`BSCTAP_ID_W-1:1]};
      end
    end
  end

  // ==========================================================
  // boundary register, one cell per bump
  logic [`BSCTAP_BSR_LEN-1:0] bsr_shift_q;

  // ring values may be mid-transition at capture; no guarantee
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bsr_shift_q <= '0;
    end else if (tck_rise && bsr_instr) begin
      if (state_q == ST_CAP_DR) begin
        bsr_shift_q <= ring_in;
      end else if (state_q == ST_SHF_DR) begin
        bsr_shift_q <= {tdi_s, bsr_shift_q[`BSCTAP_BSR_LEN-1:1]};
      end
    end
  end

  // parallel latches; clearing them also clears the output-bus cell
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bsr_par_q <= '0;
    end else if (tck_fall) begin
      if (state_q == ST_RESET) begin
        bsr_par_q <= '0;
      end else if (state_q == ST_UPD_DR && bsr_instr) begin
        bsr_par_q <= bsr_shift_q;
      end
    end
  end

  // ==========================================================
  // read-output bus control
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      extest_q <= 1'h0;
      qbus_drive_en_q <= 1'h1;
    end else begin
      extest_q <= (ir_q == `BSCTAP_INS_EXTEST);
      if (ir_q == `BSCTAP_INS_SAMPLEZ) begin
        qbus_drive_en_q <= 1'h0;
      end else if (ir_q == `BSCTAP_INS_EXTEST) begin
        qbus_drive_en_q <= bsr_par_q[`BSCTAP_OBE_CELL];
      end else begin
        qbus_drive_en_q <= 1'h1;
      end
    end
  end

  // test reset only touches test logic; memory keeps running
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tap_reset_q <= 1'h1;
    end else begin
      tap_reset_q <= (state_q == ST_RESET);
    end
  end

  // ==========================================================
  // serial output, changed on the fall only
  logic tdo_bit;
  logic shifting;

  assign shifting = (state_q == ST_SHF_DR) || (state_q == ST_SHF_IR);

  always_comb begin
    if (state_q == ST_SHF_IR) begin
      tdo_bit = ir_shift_q[0];
    end else begin
      unique case (dr_sel)
        SEL_IDENT: tdo_bit = id_shift_q[0];
        SEL_BOUNDARY: tdo_bit = bsr_shift_q[0];
        default: tdo_bit = byp_q;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tdo_out <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (tck_fall) begin
      tdo_out <= tdo_bit;
      tdo_oe <= shifting;
    end
  end

endmodule

// ==== testbench/bsctap_properties.sv ====
// checker of the test port, watching the top module's pins only.
// assumes test clock phases of at least 6 mclk each.
`timescale 1ns/10ps
`include "bsctap_regs.svh"
module bsctap_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic tck_in,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic [`BSCTAP_BSR_LEN-1:0] bsr_par_q,
  input wire logic extest_q,
  input wire logic qbus_drive_en_q,
  input wire logic tap_reset_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // output timing
  // outputs move only once the pin fall has crossed the synchroniser
  tdo_on_fall_a: assert property (
    $changed(tdo_out) |-> !$past(tck_in, 3))
    else $error("tdo changed outside a test clock fall");
  oe_on_fall_a: assert property (
    $changed(tdo_oe) |-> !$past(tck_in, 3))
    else $error("tdo enable changed outside a test clock fall");
  par_on_fall_a: assert property (
    $changed(bsr_par_q) |-> !$past(tck_in, 3))
    else $error("update latches changed outside a test clock fall");
  oe_hold_a: assert property ($rose(tdo_oe) |-> tdo_oe [*8])
    else $error("tdo enable dropped within a test clock phase");
  oe_in_reset_a: assert property (tap_reset_q |-> !tdo_oe)
    else $error("tdo driven in reset state");
  // ==========================================================
  // reset and read bus control
  reset_clear_a: assert property (
    $rose(tap_reset_q) |-> ##[1:24] (bsr_par_q == '0 && !extest_q))
    else $error("test reset left latches or extest set");
  reset_qbus_a: assert property (
    $rose(tap_reset_q) |-> ##[1:24] qbus_drive_en_q)
    else $error("read bus not released after test reset");
  obe_cell_a: assert property (
    extest_q && $past(extest_q) &&
    $stable(bsr_par_q[`BSCTAP_OBE_CELL]) |->
    qbus_drive_en_q == bsr_par_q[`BSCTAP_OBE_CELL])
    else $error("read bus enable differs from its cell");
  extest_entry_a: assert property (
    $rose(extest_q) |-> !tap_reset_q)
    else $error("extest became current in reset state");
endmodule
bind bsctap_top bsctap_checker u_chk (.mclk(mclk), .rst_b(rst_b),
  .tck_in(tck_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
  .bsr_par_q(bsr_par_q), .extest_q(extest_q),
  .qbus_drive_en_q(qbus_drive_en_q), .tap_reset_q(tap_reset_q));

// ==== testbench/bsctap_ctl_model.sv ====
// external test controller: one test clock cycle per call.
// assumes mclk at 125 MHz; a cycle takes 16 mclk.
`timescale 1ns/10ps
module bsctap_ctl_model (
  input wire logic mclk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_pin
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // tms and tdi held over the rise; tdo read just before it
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge mclk);
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge mclk);
    o = tdo_pin;
    tck <= 1'b1;
    repeat (7) @(posedge mclk);
    tck <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule

// ==== testbench/boundary_scan_tap_bench.sv ====
// self-checking bench of the test port with a controller model.
// assumes the pin ring is steady while captured.
`timescale 1ns/10ps
`include "bsctap_regs.svh"
module boundary_scan_tap_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic tck, tms, tdi, tdo_out, tdo_oe, extest_q, qbus, tap_rst;
  logic [108:0] ring = 109'h1234_5678_9ABC_DEF0_1357_9BDF;
  logic [108:0] par;
  int compares = 0;
  int miscompares = 0;
  wire tdo_pin;
  assign tdo_pin = tdo_oe ? tdo_out : 1'bz;
  always #4 mclk = ~mclk;
  bsctap_top dut (.mclk(mclk), .rst_b(rst_b), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .ring_in(ring),
    .bsr_par_q(par), .extest_q(extest_q), .qbus_drive_en_q(qbus),
    .tap_reset_q(tap_rst));
  bsctap_ctl_model u_ctl (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_pin(tdo_pin));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [108:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tk(input logic m);
    logic o;
    u_ctl.step(m, 1'b1, o);
  endtask
  // from idle through one scan and back to idle
  task automatic scan(input logic ir, input int n, input logic [108:0] di,
                      output logic [108:0] dq);
    logic o;
    dq = '0;
    tk(1'b1);
    if (ir) tk(1'b1);
    tk(1'b0);
    tk(1'b0);
    for (int i = 0; i < n; i++) begin
      u_ctl.step(i == n - 1, di[i], o);
      dq[i] = o;
      chk("tdo_oe", tdo_oe, 1'b1);
    end
    tk(1'b1);
    tk(1'b0);
    chk("tdo_oe", tdo_oe, 1'b0);
  endtask
  task automatic ld(input logic [2:0] c);
    logic [108:0] d;
    scan(1'b1, 3, 109'(c), d);
    chk("ir_capture", d[2:0], `BSCTAP_IR_CAPTURE);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_idcode;
    logic [108:0] d;
    chk("tap_reset", tap_rst, 1'b1);
    chk("tdo_oe", tdo_oe, 1'b0);
    tk(1'b0);
    scan(1'b0, 32, '0, d);
    chk("idcode", d[31:0], `BSCTAP_ID_DEFAULT);
  endtask
  task automatic t_bypass;
    logic [2:0] c [4] = '{`BSCTAP_INS_BYPASS, 3'h3, 3'h5, 3'h6};
    logic [108:0] d;
    for (int i = 0; i < 4; i++) begin
      ld(c[i]);
      scan(1'b0, 8, 109'hB5, d);
      chk("bypass", d[7:0], 8'h6A);
    end
  endtask
  task automatic t_ring;
    logic [2:0] c [4] = '{`BSCTAP_INS_SAMPLE, `BSCTAP_INS_EXTEST,
                          `BSCTAP_INS_EXTEST, `BSCTAP_INS_SAMPLEZ};
    logic [108:0] p, d;
    logic q;
    for (int i = 0; i < 4; i++) begin
      p = {i != 2, 108'hC3A_50F9_61E2_D3C4_B5A6_9788} + 109'(i);
      q = (c[i] == `BSCTAP_INS_EXTEST) ? p[108] : 1'b1;
      ld(c[i]);
      scan(1'b0, 109, p, d);
      chk("ring", d, ring);
      if (i < 3) chk("par", par, p);
      chk("extest", extest_q, c[i] == `BSCTAP_INS_EXTEST);
      chk("qbus", qbus, (i == 3) ? 1'b0 : q);
    end
  endtask
  task automatic t_treset;
    logic [108:0] d;
    tk(1'b1);
    tk(1'b0);
    tk(1'b0);
    // update-DR is passed on the way, so the latches load first
    repeat (5) tk(1'b1);
    repeat (8) @(posedge mclk);
    chk("tap_reset", tap_rst, 1'b1);
    chk("par", par, '0);
    chk("qbus", qbus, 1'b1);
    tk(1'b0);
    scan(1'b0, 32, '0, d);
    chk("idcode", d[31:0], `BSCTAP_ID_DEFAULT);
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    t_idcode();
    t_bypass();
    t_ring();
    t_treset();
    report_and_stop();
  end
endmodule
